//--- hw/bias_ctrl.sv
/*
 LCD bias enable and ramp controller: bias configuration registers,
 rail voltage codes, short flags and fault response, two rail sequencers.
 Assumes a byte register port decoded from the serial host interface and
 asynchronous enable pins and short comparators from outside.
*/
// Overview of operation
// R1: Master bias bit clear keeps both rails off, whatever the enables.
// R2: Positive discharge bit set pulls down positive rail while shut down.
// R3: Negative discharge bit set pulls down negative rail while shut down.
// R4: Pin select clear: rails enable only from their register bits.
// R5: Pin select set: rails enable only from their enable pins.
// R6: Short mode 0X flags, 10 shuts rails, 11 shuts rails and backlight.
// R7: Positive ramp time 228, 456, 684 or 912 us; default code 01.
// R8: Negative ramp time 456 us times code plus one; default code 0001.
// R9: Positive ramp is fixed slew, time scales with target over 5.75 V.
// R10: Negative ramp is fixed slew, time scales with magnitude over 5.75 V.
// R11: Positive short must persist 2 ms, 1 ms, 500 us or 100 us.
// R12: Negative short must persist for the same selectable filter times.
// R13: Reserved bits read zero and writes to them do nothing.
// R14: New rail voltage codes apply only when master register is rewritten.
// R15: Short flags latch when set and clear when the flag register is read.
module bias_ctrl
	import bias_pkg::*;
#(
	parameter logic [14:0] POS_UNIT_CYC = 15'(POS_RAMP_UNIT_CYC),
	parameter logic [14:0] NEG_UNIT_CYC = 15'(NEG_RAMP_UNIT_CYC),
	parameter logic [16:0] FILT_2MS = 17'(FILT_2MS_CYC),
	parameter logic [16:0] FILT_1MS = 17'(FILT_1MS_CYC),
	parameter logic [16:0] FILT_500US = 17'(FILT_500US_CYC),
	parameter logic [16:0] FILT_100US = 17'(FILT_100US_CYC)
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic pos_rail_enable_pin_i,
	input wire logic neg_rail_enable_pin_i,
	input wire logic pos_short_i,
	input wire logic neg_short_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	output logic pos_rail_on_o,
	output logic neg_rail_on_o,
	output logic pos_rail_ramping_o,
	output logic neg_rail_ramping_o,
	output logic pos_rail_pulldown_o,
	output logic neg_rail_pulldown_o,
	output logic [5:0] pos_vcode_o,
	output logic [5:0] neg_vcode_o,
	output logic backlight_off_o
);
	typedef struct packed {
		logic [7:0] master;
		logic [7:0] ramp;
		logic [7:0] filt;
		logic [5:0] pos_code;
		logic [5:0] neg_code;
		logic [5:0] pos_app;
		logic [5:0] neg_app;
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
		logic [3:0] lvl;
		logic flag_p;
		logic flag_n;
		logic fault_shut;
		logic bl_off;
		logic [7:0] rdata;
		logic rvalid;
	} ctrl_type;

	ctrl_type st;
	ctrl_type next_st;
	logic [1:0] rail_en;
	logic [1:0] rail_evt;
	logic [1:0] rail_on;
	logic [1:0] rail_ramp;
	logic [1:0] rail_pd;

	function automatic logic [16:0] filt_cycles(input logic [1:0] c);
		unique case (c)
			2'b00: return FILT_2MS;
			2'b01: return FILT_1MS;
			2'b10: return FILT_500US;
			default: return FILT_100US;
		endcase
	endfunction

	// Synchronised bits: 0 pos pin, 1 neg pin, 2 pos short, 3 neg short
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			rail_en[i] = st.master[BIT_MASTER_ON] && !st.fault_shut // R1
				&& (st.master[BIT_PIN_SEL] ? st.lvl[i] // R5
				: st.master[i == RAIL_POS ? BIT_POS_EN : BIT_NEG_EN]); // R4
		end
	end

	always_comb begin
		next_st = st;
		next_st.s1 = {neg_short_i, pos_short_i,
			neg_rail_enable_pin_i, pos_rail_enable_pin_i};
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// A level counts only once the last two stages agree
		next_st.lvl = (st.s2 & st.s3) | (st.lvl & (st.s2 ^ st.s3));
		next_st.rvalid = 1'b0;
		if (reg_wr_i) begin
			case (reg_addr_i)
				ADDR_MASTER: begin
					next_st.master = reg_wdata_i & MASK_MASTER; // R13
					next_st.pos_app = st.pos_code; // R14
					next_st.neg_app = st.neg_code; // R14
					// Rewriting the master register rearms after a fault
					next_st.fault_shut = 1'b0;
					next_st.bl_off = 1'b0;
				end
				ADDR_RAMP: next_st.ramp = reg_wdata_i;
				ADDR_FILT: next_st.filt = reg_wdata_i & MASK_FILT; // R13
				ADDR_POS_V: next_st.pos_code = reg_wdata_i[5:0];
				ADDR_NEG_V: next_st.neg_code = reg_wdata_i[5:0];
				default: ;
			endcase
		end
		if (reg_rd_i) begin
			next_st.rvalid = 1'b1;
			case (reg_addr_i)
				ADDR_MASTER: next_st.rdata = st.master;
				ADDR_RAMP: next_st.rdata = st.ramp;
				ADDR_FILT: next_st.rdata = st.filt;
				ADDR_POS_V: next_st.rdata = {2'h0, st.pos_code};
				ADDR_NEG_V: next_st.rdata = {2'h0, st.neg_code};
				ADDR_FLAG: begin
					next_st.rdata = 8'h00;
					next_st.rdata[FLAG_POS_BIT] = st.flag_p;
					next_st.rdata[FLAG_NEG_BIT] = st.flag_n;
					next_st.flag_p = 1'b0; // R15
					next_st.flag_n = 1'b0; // R15
				end
				default: next_st.rdata = 8'h00;
			endcase
		end
		// Events come last so a set beats a same-cycle clear
		if (rail_evt[RAIL_POS]) begin
			next_st.flag_p = 1'b1; // R15
		end
		if (rail_evt[RAIL_NEG]) begin
			next_st.flag_n = 1'b1; // R15
		end
		if (|rail_evt && st.ramp[SHORT_MODE_LSB + 1]) begin
			next_st.fault_shut = 1'b1; // R6
			if (st.ramp[SHORT_MODE_LSB]) begin
				next_st.bl_off = 1'b1; // R6
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st <= '{master: RST_MASTER, ramp: RST_RAMP, filt: RST_FILT,
				pos_code: RST_POS_V, neg_code: RST_NEG_V,
				pos_app: RST_POS_V, neg_app: RST_NEG_V, default: '0};
		end else begin
			st <= next_st;
		end
	end

	for (genvar g = 0; g < 2; g++) begin : g_rail
		localparam bit IS_POS = g == RAIL_POS;
		rail_seq u_rail (
			.clk_i(clk_i),
			.srst_i(srst_i),
			.enable_i(rail_en[g]),
			.discharge_i(st.master[IS_POS ? BIT_POS_PD : BIT_NEG_PD]),
			.short_i(st.lvl[2 + g]),
			.ramp_unit_i(IS_POS ? POS_UNIT_CYC : NEG_UNIT_CYC),
			.ramp_code_i(IS_POS ? {2'h0, st.ramp[POS_RAMP_LSB +: 2]}
				: st.ramp[NEG_RAMP_LSB +: 4]), // R7 R8
			.target_units_i(target_units(IS_POS ? st.pos_app
				: st.neg_app)), // R9 R10
			.filt_cycles_i(filt_cycles(IS_POS ? st.filt[POS_FILT_LSB +: 2]
				: st.filt[NEG_FILT_LSB +: 2])), // R11 R12
			.rail_on_o(rail_on[g]),
			.ramping_o(rail_ramp[g]),
			.pulldown_o(rail_pd[g]),
			.short_evt_o(rail_evt[g])
		);
	end

	assign reg_rdata_o = st.rdata;
	assign reg_rvalid_o = st.rvalid;
	assign pos_rail_on_o = rail_on[RAIL_POS];
	assign neg_rail_on_o = rail_on[RAIL_NEG];
	assign pos_rail_ramping_o = rail_ramp[RAIL_POS];
	assign neg_rail_ramping_o = rail_ramp[RAIL_NEG];
	assign pos_rail_pulldown_o = rail_pd[RAIL_POS];
	assign neg_rail_pulldown_o = rail_pd[RAIL_NEG];
	assign pos_vcode_o = st.pos_app;
	assign neg_vcode_o = st.neg_app;
	assign backlight_off_o = st.bl_off;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	master_off_a: assert property ( // R1
		!st.master[BIT_MASTER_ON] |=> !pos_rail_on_o && !neg_rail_on_o)
		else $error("rail on while master bias bit clear");
	reg_enable_a: assert property ( // R4
		!st.master[BIT_PIN_SEL] && !st.master[BIT_POS_EN]
		|=> !pos_rail_on_o)
		else $error("positive rail on with register enable clear");
	pin_enable_a: assert property ( // R5
		st.master[BIT_PIN_SEL] && !st.lvl[1] |=> !neg_rail_on_o)
		else $error("negative rail on with its pin low");
	fault_mode_a: assert property ( // R6
		|rail_evt && st.ramp[7:6] == 2'b11
		|=> st.fault_shut && backlight_off_o
		##1 !pos_rail_on_o && !neg_rail_on_o)
		else $error("full shutdown not applied on short");
	flag_only_a: assert property ( // R6
		!st.ramp[SHORT_MODE_LSB + 1] && !st.fault_shut
		&& !(reg_wr_i && reg_addr_i == ADDR_MASTER) |=> !st.fault_shut)
		else $error("rails shut in flag-only mode");
	reserved_zero_a: assert property ( // R13
		reg_rd_i && reg_addr_i == ADDR_FILT |=> reg_rdata_o[7:4] == 4'h0)
		else $error("reserved bits read nonzero");
	code_apply_a: assert property ( // R14
		pos_vcode_o != $past(pos_vcode_o)
		|-> $past(reg_wr_i && reg_addr_i == ADDR_MASTER))
		else $error("voltage code applied without master write");
	flag_set_a: assert property ( // R15
		rail_evt[RAIL_NEG] |=> st.flag_n)
		else $error("short flag lost on same-cycle read");
endmodule // bias_ctrl

//--- hw/bias_pkg.sv
/*
 Shared constants for the LCD bias enable and ramp controller: register
 addresses, field positions, reset values, timing and the rail state type.
 Assumes a 40 MHz core clock.
*/
package bias_pkg;
	localparam int CLK_PERIOD_NS = 25;

	localparam logic [7:0] ADDR_MASTER = 8'h09;
	localparam logic [7:0] ADDR_RAMP = 8'h0a;
	localparam logic [7:0] ADDR_FILT = 8'h0b;
	localparam logic [7:0] ADDR_POS_V = 8'h0d;
	localparam logic [7:0] ADDR_NEG_V = 8'h0e;
	localparam logic [7:0] ADDR_FLAG = 8'h0f;

	localparam logic [7:0] RST_MASTER = 8'h18;
	localparam logic [7:0] RST_RAMP = 8'h11;
	localparam logic [7:0] RST_FILT = 8'h00;
	localparam logic [5:0] RST_POS_V = 6'h1e;
	localparam logic [5:0] RST_NEG_V = 6'h1c;

	localparam logic [7:0] MASK_MASTER = 8'h9f;
	localparam logic [7:0] MASK_FILT = 8'h0f;

	localparam int BIT_MASTER_ON = 7;
	localparam int BIT_POS_PD = 4;
	localparam int BIT_NEG_PD = 3;
	localparam int BIT_POS_EN = 2;
	localparam int BIT_NEG_EN = 1;
	localparam int BIT_PIN_SEL = 0;
	localparam int FLAG_POS_BIT = 5;
	localparam int FLAG_NEG_BIT = 4;
	localparam int SHORT_MODE_LSB = 6;
	localparam int POS_RAMP_LSB = 4;
	localparam int NEG_RAMP_LSB = 0;
	localparam int POS_FILT_LSB = 2;
	localparam int NEG_FILT_LSB = 0;

	// Rail index inside the two-rail generate loop
	localparam int RAIL_POS = 0;
	localparam int RAIL_NEG = 1;

	localparam int POS_RAMP_UNIT_NS = 228000;
	localparam int NEG_RAMP_UNIT_NS = 456000;
	localparam int FILT_2MS_NS = 2000000;
	localparam int FILT_1MS_NS = 1000000;
	localparam int FILT_500US_NS = 500000;
	localparam int FILT_100US_NS = 100000;
	localparam int POS_RAMP_UNIT_CYC =
		(POS_RAMP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NEG_RAMP_UNIT_CYC =
		(NEG_RAMP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILT_2MS_CYC =
		(FILT_2MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILT_1MS_CYC =
		(FILT_1MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILT_500US_CYC =
		(FILT_500US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILT_100US_CYC =
		(FILT_100US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Voltages in 50 mV units: rail = 4 V + code, slew reference 5.75 V
	localparam logic [6:0] BASE_UNITS = 7'h50;
	localparam logic [26:0] SLEW_REF_UNITS = 27'h73;
	localparam logic [5:0] CODE_MAX = 6'h2e;

	typedef enum logic [1:0] {
		RAIL_OFF = 2'b00,
		RAIL_RAMP = 2'b01,
		RAIL_ON = 2'b11
	} rail_state_type;

	// Codes above the ceiling clamp to 6.3 V
	function automatic logic [6:0] target_units(input logic [5:0] code);
		logic [5:0] c;
		c = (code > CODE_MAX) ? CODE_MAX : code;
		return BASE_UNITS + {1'b0, c};
	endfunction
endpackage

//--- hw/rail_seq.sv
/*
 One bias rail: enable sequencing with a fixed-slew ramp, shutdown
 pulldown and short-circuit persistence filter.
 Assumes short_i is already synchronised and enable_i is same-clock logic.
*/
module rail_seq
	import bias_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic enable_i,
	input wire logic discharge_i,
	input wire logic short_i,
	input wire logic [14:0] ramp_unit_i,
	input wire logic [3:0] ramp_code_i,
	input wire logic [6:0] target_units_i,
	input wire logic [16:0] filt_cycles_i,
	output logic rail_on_o,
	output logic ramping_o,
	output logic pulldown_o,
	output logic short_evt_o
);
	typedef struct packed {
		rail_state_type mode;
		logic [26:0] acc;
		logic [16:0] fcnt;
		logic on;
		logic ramping;
		logic pd;
		logic evt;
	} rail_type;

	rail_type st;
	rail_type next_st;
	logic [26:0] limit;

	// Fixed slew: the table time at 5.75 V, scaled by the real target
	assign limit = 27'(ramp_unit_i) * 27'(ramp_code_i + 5'h1)
		* 27'(target_units_i); // R9 R10

	always_comb begin
		next_st = st;
		next_st.evt = 1'b0;
		unique case (st.mode)
			RAIL_OFF: begin
				next_st.acc = 27'h0;
				if (enable_i) begin
					next_st.mode = RAIL_RAMP;
				end
			end
			RAIL_RAMP: begin
				if (!enable_i) begin
					next_st.mode = RAIL_OFF;
				end else if (st.acc + SLEW_REF_UNITS >= limit) begin
					next_st.mode = RAIL_ON; // R7 R8
				end else begin
					next_st.acc = st.acc + SLEW_REF_UNITS; // R7 R8
				end
			end
			RAIL_ON: begin
				if (!enable_i) begin
					next_st.mode = RAIL_OFF;
				end
			end
		endcase
		// A short that lapses even once restarts the filter
		if (short_i && st.mode != RAIL_OFF) begin
			if (st.fcnt + 17'h1 >= filt_cycles_i) begin
				next_st.evt = 1'b1; // R11 R12
				next_st.fcnt = 17'h0;
			end else begin
				next_st.fcnt = st.fcnt + 17'h1;
			end
		end else begin
			next_st.fcnt = 17'h0;
		end
		next_st.on = next_st.mode != RAIL_OFF;
		next_st.ramping = next_st.mode == RAIL_RAMP;
		next_st.pd = next_st.mode == RAIL_OFF && discharge_i; // R2 R3
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st <= '{mode: RAIL_OFF, default: '0};
		end else begin
			st <= next_st;
		end
	end

	assign rail_on_o = st.on;
	assign ramping_o = st.ramping;
	assign pulldown_o = st.pd;
	assign short_evt_o = st.evt;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sequence ramp_end_s;
		st.mode == RAIL_RAMP && enable_i
			&& st.acc + SLEW_REF_UNITS >= limit;
	endsequence

	ramp_finish_a: assert property (ramp_end_s |=> st.mode == RAIL_ON) // R7
		else $error("ramp did not finish at its limit");
	slew_step_a: assert property ( // R9
		st.mode == RAIL_RAMP && $past(st.mode) == RAIL_RAMP
		|-> st.acc == $past(st.acc) + SLEW_REF_UNITS)
		else $error("ramp accumulator did not advance by one step");
	pulldown_off_a: assert property ( // R2
		pulldown_o |-> !rail_on_o && $past(discharge_i))
		else $error("pulldown while rail on or discharge disabled");
	short_filter_a: assert property ( // R11
		short_evt_o |-> $past(short_i)
		&& $past(st.fcnt) + 17'h1 >= $past(filt_cycles_i))
		else $error("short event before filter time elapsed");
endmodule // rail_seq

//--- testbench/bias_ctrl_tb_top.sv
/*
 Bench for the bias controller: register table, enable paths, ramp and
 short filter timing. Assumes the shortened counts given at the instance.
*/
module bias_ctrl_tb_top;
	import bias_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [1:0] pins;
		logic [7:0] rd;
		logic [3:0] st;
	} row_type;
	// The 100 us filter keeps its real length, so its default is exercised
	localparam int FILT [4] = '{40, 20, 10, FILT_100US_CYC};
	localparam logic [1:0] MODES [4] = '{2'h2, 2'h3, 2'h1, 2'h2};
	// Status column: pos on, neg on, pos pulldown, neg pulldown
	localparam row_type ROWS [14] = '{
		'{1'h0, 8'h09, 8'h00, 2'h0, 8'h18, 4'h3},
		'{1'h0, 8'h0a, 8'h00, 2'h0, 8'h11, 4'h3},
		'{1'h0, 8'h0b, 8'h00, 2'h0, 8'h00, 4'h3},
		'{1'h1, 8'h0b, 8'hff, 2'h0, 8'h0f, 4'h3},
		'{1'h1, 8'h0b, 8'h00, 2'h0, 8'h00, 4'h3},
		'{1'h1, 8'h0f, 8'hff, 2'h0, 8'h00, 4'h3},
		'{1'h1, 8'h33, 8'hff, 2'h0, 8'h00, 4'h3},
		'{1'h1, 8'h09, 8'h66, 2'h3, 8'h06, 4'h0},
		'{1'h1, 8'h09, 8'h86, 2'h0, 8'h86, 4'hc},
		'{1'h1, 8'h09, 8'h98, 2'h3, 8'h98, 4'h3},
		'{1'h1, 8'h09, 8'h87, 2'h0, 8'h87, 4'h0},
		'{1'h1, 8'h09, 8'h99, 2'h1, 8'h99, 4'h6},
		'{1'h1, 8'h09, 8'h9d, 2'h2, 8'h9d, 4'h9},
		'{1'h1, 8'h09, 8'h00, 2'h0, 8'h00, 4'h0}
	};
	logic clk, srst, wr, rd, rvalid, bl_off;
	logic p_on, n_on, p_rmp, n_rmp, p_pd, n_pd;
	logic pin_p, pin_n, sh_p, sh_n;
	logic [1:0] pins, shorts;
	logic [7:0] addr, wdata, rdata;
	logic [5:0] pv, nv;
	int bad_count = 0;
	int checks = 0;

	far_side i_far_side (.clk_i(clk), .pins_i(pins), .short_i(shorts),
		.pos_pin_o(pin_p), .neg_pin_o(pin_n), .pos_short_o(sh_p),
		.neg_short_o(sh_n));

	bias_ctrl #(.POS_UNIT_CYC(15'h14), .NEG_UNIT_CYC(15'h28),
		.FILT_2MS(17'h28), .FILT_1MS(17'h14), .FILT_500US(17'ha))
		i_bias_ctrl (.clk_i(clk), .srst_i(srst),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd), .pos_rail_enable_pin_i(pin_p),
		.neg_rail_enable_pin_i(pin_n), .pos_short_i(sh_p),
		.neg_short_i(sh_n), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
		.pos_rail_on_o(p_on), .neg_rail_on_o(n_on),
		.pos_rail_ramping_o(p_rmp), .neg_rail_ramping_o(n_rmp),
		.pos_rail_pulldown_o(p_pd), .neg_rail_pulldown_o(n_pd),
		.pos_vcode_o(pv), .neg_vcode_o(nv), .backlight_off_o(bl_off));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
		// Let an edge pass so a following call never re-raises the strobe
		tick(1);
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		addr = a;
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
		chk("rvalid", 32'(rvalid), 32'h1);
		d = rdata;
		tick(1);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Fixed slew: time scales with clamped target over the 5.75 V point
	function automatic int ramp(int unit, int code, int v);
		int vv;
		vv = (v > 46) ? 46 : v;
		return (unit * (code + 1) * (80 + vv) + 114) / 115;
	endfunction

	initial begin
		logic [7:0] d;
		int np, nn, g, c;
		srst = 1'b1;
		{addr, wdata, wr, rd, pins, shorts} = '0;
		tick(5);
		srst = 1'b0;
		tick(1);
		foreach (ROWS[i]) begin
			pins = ROWS[i].pins;
			if (ROWS[i].wr)
				wr_reg(ROWS[i].addr, ROWS[i].wdata);
			tick(8);
			rd_reg(ROWS[i].addr, d);
			chk("reg", 32'(d), 32'(ROWS[i].rd));
			chk("rails", 32'({p_on, n_on, p_pd, n_pd}), 32'(ROWS[i].st));
		end
		wr_reg(8'h0d, 8'h3f);
		wr_reg(8'h0e, 8'h05);
		chk("pos code held", 32'(pv), 32'h1e);
		for (int k = 0; k < 4; k++) begin
			wr_reg(8'h0a, {2'h0, 2'(k), 4'(k * 5)});
			wr_reg(8'h09, 8'h86);
			chk("codes", 32'({pv, nv}), 32'h0fc5);
			np = 0;
			nn = 0;
			g = 0;
			while ((p_rmp === 1'b1 || n_rmp === 1'b1) && g < 3000) begin
				np += 32'(p_rmp);
				nn += 32'(n_rmp);
				g++;
				tick(1);
			end
			if (g >= 3000) begin
				bad_count++;
				tally_and_finish();
			end
			chk("pos ramp", np, ramp(20, k, 63));
			chk("neg ramp", nn, ramp(40, k * 5, 5));
			wr_reg(8'h09, 8'h00);
			tick(2);
		end
		// Even passes short the positive rail, odd ones the negative
		for (int k = 0; k < 4; k++) begin
			wr_reg(8'h0b, {4'h0, 2'(k), 2'(k)});
			wr_reg(8'h0a, {MODES[k], 6'h00});
			wr_reg(8'h09, 8'h86);
			tick(2);
			shorts = k[0] ? 2'h1 : 2'h2;
			c = 0;
			while (p_on === 1'b1 && n_on === 1'b1 && c < FILT[k] + 200) begin
				tick(1);
				c++;
			end
			if (k == 2)
				chk("flag only", c, FILT[k] + 200);
			else
				chk("filter", (c >= FILT[k] + 3 && c <= FILT[k] + 10), 1);
			shorts = 2'h0;
			tick(8);
			chk("backlight", 32'(bl_off), (k == 1));
			rd_reg(8'h0f, d);
			chk("flag", 32'(d), k[0] ? 32'h10 : 32'h20);
			rd_reg(8'h0f, d);
			chk("flag cleared", 32'(d), 32'h0);
			wr_reg(8'h09, 8'h00);
			tick(1);
			chk("backlight off", 32'(bl_off), 32'h0);
		end
		tally_and_finish();
	end
endmodule // bias_ctrl_tb_top

//--- testbench/far_side.sv
/*
 Far side of the bias block: the system's enable pins and the rail short
 comparators. Assumes the bench sets wanted levels between clock edges.
*/
module far_side (
	input wire logic clk_i,
	input wire logic [1:0] pins_i,
	input wire logic [1:0] short_i,
	output logic pos_pin_o,
	output logic neg_pin_o,
	output logic pos_short_o,
	output logic neg_short_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{pos_pin_o, neg_pin_o, pos_short_o, neg_short_o} = 4'h0;
	end
	// Levels move just after an edge, unrelated to the register strobes
	always @(posedge clk_i) begin
		#1;
		{pos_pin_o, neg_pin_o} <= pins_i;
		{pos_short_o, neg_short_o} <= short_i;
	end
endmodule // far_side
